// >>> design/fsdl_pkg.sv
// Constants and types for the framestore DRAM and local bus port.
// Assumes one 50 MHz double-rate memory clock and a synchronous reset.
package fsdl_pkg;
  // ****************************************
  // Bus shapes
  // ****************************************
  localparam int DATA_W = 32;
  localparam int ADDR_W = 9;
  localparam int LANES = 4;
  localparam int BANKS = 4;
  localparam int LOC_ADDR_W = 15;
  localparam int LOC_ADDR_LSB = 16;
  localparam int LOC_RW_BIT = 31;
  localparam int DAC_REG_LSB = 8;
  localparam int BYTE_W = 8;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int MCLK_DIV = 2; // Double-rate edges per internal memory clock
  localparam logic [LANES-1:0] CAS_IDLE = 4'hF;
  localparam logic [BANKS-1:0] OE_IDLE = 4'hF;
  // ****************************************
  // Request targets and sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    TGT_DRAM, TGT_ROM, TGT_AUX, TGT_DAC_PIX, TGT_DAC_REG
  } fsdl_target_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ROW, ST_COL, ST_PRE, ST_LSET, ST_LSTB, ST_LHLD
  } fsdl_state_t;
endpackage : fsdl_pkg

// >>> design/fsdl_port.sv
// Framestore DRAM sequencer sharing the memory data bus with ROM, auxiliary
// device and palette-DAC. Assumes the user side runs on ref_clk and holds
// a request stable while req_valid is high and req_ready is low.
`timescale 1ns/10ps
module fsdl_port (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // User request
  input wire logic req_valid,
  output logic req_ready,
  input wire fsdl_pkg::fsdl_target_t req_target,
  input wire logic req_write,
  input wire logic [1:0] req_bank,
  input wire logic [fsdl_pkg::ADDR_W-1:0] req_row,
  input wire logic [fsdl_pkg::ADDR_W-1:0] req_col,
  input wire logic [fsdl_pkg::LANES-1:0] req_byte_en,
  input wire logic [fsdl_pkg::LOC_ADDR_W-1:0] req_loc_addr,
  input wire logic [fsdl_pkg::DATA_W-1:0] req_wdata,
  // User answer
  output logic resp_valid,
  output logic [fsdl_pkg::DATA_W-1:0] resp_rdata,
  // Framestore configuration
  input wire logic isolate_req,
  output logic transceiver_isolate,
  output logic mem_clock_half,
  // Memory data bus
  input wire logic [fsdl_pkg::DATA_W-1:0] mem_data_bus_in,
  output logic [fsdl_pkg::DATA_W-1:0] mem_data_bus_out,
  output logic [fsdl_pkg::DATA_W-1:0] mem_data_bus_oe,
  // DRAM control
  output logic [fsdl_pkg::ADDR_W-1:0] addr_banks_even_pair,
  output logic [fsdl_pkg::ADDR_W-1:0] addr_banks_odd_pair,
  output logic row_strobe_n,
  output logic [fsdl_pkg::LANES-1:0] col_strobe_pair_a_n,
  output logic [fsdl_pkg::LANES-1:0] col_strobe_pair_b_n,
  output logic write_en_banks_zero_three_n,
  output logic write_en_banks_one_two_n,
  output logic [fsdl_pkg::BANKS-1:0] bank_out_en_n,
  // Local devices
  output logic boot_rom_select_n,
  output logic aux_device_select_n,
  output logic palette_dac_select_n,
  output logic pixel_load_clock,
  output logic pixel_load_enable_n
);
  // ****************************************
  // Half-rate phase and request capture
  // ****************************************
  fsdl_pkg::fsdl_state_t state_q, state_d, nxt;
  fsdl_pkg::fsdl_target_t tgt_q;
  logic phase_q;
  logic wr_q;
  logic [1:0] bank_q;
  logic [fsdl_pkg::ADDR_W-1:0] row_q, col_q;
  logic [fsdl_pkg::LANES-1:0] be_q;
  logic [fsdl_pkg::LOC_ADDR_W-1:0] laddr_q;
  logic [fsdl_pkg::DATA_W-1:0] wdata_q;
  wire step = phase_q; // Second edge of each internal memory clock
  wire take = req_valid && req_ready;
  // Only complete internal clock periods start a request
  assign req_ready = (state_q == fsdl_pkg::ST_IDLE) && step;
  assign mem_clock_half = phase_q;

  // Phase toggles on every double-rate edge
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= ~phase_q;
    end
  end

  // Latch the request so the pins never see it change mid-cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tgt_q <= fsdl_pkg::TGT_DRAM;
      wr_q <= 1'b0;
      bank_q <= 2'h0;
      row_q <= '0;
      col_q <= '0;
      be_q <= '0;
      laddr_q <= '0;
      wdata_q <= '0;
    end else if (take) begin
      tgt_q <= req_target;
      // ROM is read only, pixel load is write only
      wr_q <= (req_target == fsdl_pkg::TGT_DAC_PIX) ||
              (req_write && req_target != fsdl_pkg::TGT_ROM);
      bank_q <= req_bank;
      row_q <= req_row;
      col_q <= req_col;
      be_q <= req_byte_en;
      laddr_q <= req_loc_addr;
      wdata_q <= req_wdata;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // One state per internal memory clock; the bus owner is fixed by state,
  // so DRAM and local devices can never be enabled together
  always_comb begin
    nxt = state_q;
    unique case (state_q)
      fsdl_pkg::ST_IDLE: begin
        if (take) begin
          nxt = (req_target == fsdl_pkg::TGT_DRAM) ? fsdl_pkg::ST_ROW : fsdl_pkg::ST_LSET;
        end
      end
      fsdl_pkg::ST_ROW: nxt = fsdl_pkg::ST_COL;
      fsdl_pkg::ST_COL: nxt = fsdl_pkg::ST_PRE;
      fsdl_pkg::ST_PRE: nxt = fsdl_pkg::ST_IDLE;
      fsdl_pkg::ST_LSET: nxt = fsdl_pkg::ST_LSTB;
      fsdl_pkg::ST_LSTB: nxt = fsdl_pkg::ST_LHLD;
      fsdl_pkg::ST_LHLD: nxt = fsdl_pkg::ST_IDLE;
    endcase
    state_d = step ? nxt : state_q;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= fsdl_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Pin decode from the next state
  // ****************************************
  // Decoding on state_d lets every pin come straight from a flip-flop
  wire tk = (state_q == fsdl_pkg::ST_IDLE) && take;
  fsdl_pkg::fsdl_target_t t;
  logic w;
  logic [1:0] b;
  assign t = tk ? req_target : tgt_q;
  assign w = tk ? ((req_target == fsdl_pkg::TGT_DAC_PIX) ||
                   (req_write && req_target != fsdl_pkg::TGT_ROM)) : wr_q;
  assign b = tk ? req_bank : bank_q;
  // Request fields pass straight through on the take edge, so a strobe or
  // select never goes out with the address or data of the previous request
  wire [fsdl_pkg::ADDR_W-1:0] r = tk ? req_row : row_q;
  wire [fsdl_pkg::LOC_ADDR_W-1:0] la = tk ? req_loc_addr : laddr_q;
  wire [fsdl_pkg::DATA_W-1:0] wd = tk ? req_wdata : wdata_q;
  wire n_row = state_d == fsdl_pkg::ST_ROW;
  wire n_col = state_d == fsdl_pkg::ST_COL;
  wire n_loc = state_d inside {fsdl_pkg::ST_LSET, fsdl_pkg::ST_LSTB, fsdl_pkg::ST_LHLD};
  wire n_sel = state_d inside {fsdl_pkg::ST_LSET, fsdl_pkg::ST_LSTB};
  wire odd = b[0];
  wire pix = t == fsdl_pkg::TGT_DAC_PIX;
  wire [fsdl_pkg::ADDR_W-1:0] mux_addr = n_row ? r : col_q;
  wire [fsdl_pkg::ADDR_W-1:0] n_even = ((n_row || n_col) && !odd) ? mux_addr : '0;
  wire [fsdl_pkg::ADDR_W-1:0] n_odd = ((n_row || n_col) && odd) ? mux_addr : '0;
  wire n_ras_n = !(n_row || n_col);
  wire [fsdl_pkg::LANES-1:0] n_cas_a = (n_col && !odd) ? ~be_q : fsdl_pkg::CAS_IDLE;
  wire [fsdl_pkg::LANES-1:0] n_cas_b = (n_col && odd) ? ~be_q : fsdl_pkg::CAS_IDLE;
  wire n_write_en_banks_zero_three_n_n = !(n_col && w && (b == 2'd0 || b == 2'd3));
  wire n_write_en_banks_one_two_n_n = !(n_col && w && (b == 2'd1 || b == 2'd2));
  // Only the addressed bank may turn its outputs on
  wire [fsdl_pkg::BANKS-1:0] n_oe_n = (n_col && !w) ? ~(4'h1 << b) : fsdl_pkg::OE_IDLE;
  wire n_rom_n = !(n_sel && t == fsdl_pkg::TGT_ROM);
  wire n_aux_n = !(n_sel && t == fsdl_pkg::TGT_AUX);
  wire n_dac_n = !(n_sel && (pix || t == fsdl_pkg::TGT_DAC_REG));
  wire n_lden_n = !(n_sel && pix);
  // Clock rises one internal cycle after data and load enable settle
  wire n_lclk = pix && (state_d inside {fsdl_pkg::ST_LSTB, fsdl_pkg::ST_LHLD});

  // Data bus: DRAM write word, pixel word, or address/R-W plus a byte lane
  wire [fsdl_pkg::DATA_W-1:0] lhdr = {~w, la, 16'h0000};
  wire [fsdl_pkg::DATA_W-1:0] lhdr_oe = {1'b1, {fsdl_pkg::LOC_ADDR_W{1'b1}}, 16'h0000};
  wire is_reg = t == fsdl_pkg::TGT_DAC_REG;
  wire [fsdl_pkg::DATA_W-1:0] lbyte = is_reg ?
    {16'h0000, wd[fsdl_pkg::BYTE_W-1:0], 8'h00} : {24'h00_0000, wd[7:0]};
  wire [fsdl_pkg::DATA_W-1:0] lbyte_oe = !w ? '0 : (is_reg ? 32'h0000_FF00 : 32'h0000_00FF);
  wire [fsdl_pkg::DATA_W-1:0] n_dout = (n_col || pix) ? wd : (lhdr | lbyte);
  wire [fsdl_pkg::DATA_W-1:0] n_doe = (n_col && w) || (n_loc && pix) ? '1 :
                                      n_loc ? (lhdr_oe | lbyte_oe) : '0;

  // Pin registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      addr_banks_even_pair <= '0;
      addr_banks_odd_pair <= '0;
      row_strobe_n <= 1'b1;
      col_strobe_pair_a_n <= fsdl_pkg::CAS_IDLE;
      col_strobe_pair_b_n <= fsdl_pkg::CAS_IDLE;
      write_en_banks_zero_three_n <= 1'b1;
      write_en_banks_one_two_n <= 1'b1;
      bank_out_en_n <= fsdl_pkg::OE_IDLE;
      boot_rom_select_n <= 1'b1;
      aux_device_select_n <= 1'b1;
      palette_dac_select_n <= 1'b1;
      pixel_load_enable_n <= 1'b1;
      pixel_load_clock <= 1'b0;
      mem_data_bus_out <= '0;
      mem_data_bus_oe <= '0;
      transceiver_isolate <= 1'b1;
    end else begin
      addr_banks_even_pair <= n_even;
      addr_banks_odd_pair <= n_odd;
      row_strobe_n <= n_ras_n;
      col_strobe_pair_a_n <= n_cas_a;
      col_strobe_pair_b_n <= n_cas_b;
      write_en_banks_zero_three_n <= n_write_en_banks_zero_three_n_n;
      write_en_banks_one_two_n <= n_write_en_banks_one_two_n_n;
      bank_out_en_n <= n_oe_n;
      boot_rom_select_n <= n_rom_n;
      aux_device_select_n <= n_aux_n;
      palette_dac_select_n <= n_dac_n;
      pixel_load_enable_n <= n_lden_n;
      pixel_load_clock <= n_lclk;
      mem_data_bus_out <= n_dout;
      mem_data_bus_oe <= n_doe;
      transceiver_isolate <= isolate_req;
    end
  end

  // ****************************************
  // Answer
  // ****************************************
  // Read data is sampled at the end of the strobe phase, while still enabled
  wire fin = step && (state_q == fsdl_pkg::ST_COL || state_q == fsdl_pkg::ST_LSTB);
  wire [fsdl_pkg::DATA_W-1:0] rd_sel = (tgt_q == fsdl_pkg::TGT_DRAM) ? mem_data_bus_in :
    (tgt_q == fsdl_pkg::TGT_DAC_REG) ? {24'h00_0000, mem_data_bus_in[15:8]} :
    {24'h00_0000, mem_data_bus_in[7:0]};
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      resp_valid <= 1'b0;
      resp_rdata <= '0;
    end else begin
      resp_valid <= fin;
      if (fin && !wr_q) begin
        resp_rdata <= rd_sel;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_cas_in_ras;
    @(posedge ref_clk) disable iff (rst)
    (col_strobe_pair_a_n != fsdl_pkg::CAS_IDLE || col_strobe_pair_b_n != fsdl_pkg::CAS_IDLE)
      |-> !row_strobe_n;
  endproperty
  a_cas_in_ras: assert property (p_cas_in_ras) else $error("column strobe without row");
  property p_row_first;
    @(posedge ref_clk) disable iff (rst)
    $fell(row_strobe_n) |->
      (col_strobe_pair_a_n == fsdl_pkg::CAS_IDLE && col_strobe_pair_b_n == fsdl_pkg::CAS_IDLE)[*2];
  endproperty
  a_row_first: assert property (p_row_first) else $error("row phase too short");
  property p_excl;
    @(posedge ref_clk) disable iff (rst)
    (bank_out_en_n != fsdl_pkg::OE_IDLE) |->
      (boot_rom_select_n && aux_device_select_n && palette_dac_select_n);
  endproperty
  a_excl: assert property (p_excl) else $error("bank enable overlaps local select");
  property p_one_bank;
    @(posedge ref_clk) disable iff (rst) $onehot0(~bank_out_en_n) && !(|(bank_out_en_n ^
      fsdl_pkg::OE_IDLE) && |mem_data_bus_oe);
  endproperty
  a_one_bank: assert property (p_one_bank) else $error("bus contention on read");
  property p_we_cas;
    @(posedge ref_clk) disable iff (rst)
    !(write_en_banks_zero_three_n && write_en_banks_one_two_n) |->
      (mem_data_bus_oe == '1 && !row_strobe_n);
  endproperty
  a_we_cas: assert property (p_we_cas) else $error("write without driven data");
  property p_half;
    @(posedge ref_clk) disable iff (rst) mem_clock_half |=> !mem_clock_half ##1 mem_clock_half;
  endproperty
  a_half: assert property (p_half) else $error("memory clock not half rate");
  property p_load;
    @(posedge ref_clk) disable iff (rst)
    $rose(pixel_load_clock) |-> !pixel_load_enable_n && $stable(mem_data_bus_out) &&
      mem_data_bus_oe == '1;
  endproperty
  a_load: assert property (p_load) else $error("pixel data unstable at load edge");
  property p_rom;
    @(posedge ref_clk) disable iff (rst)
    !boot_rom_select_n |-> mem_data_bus_out[31] && mem_data_bus_oe[31:16] == 16'hFFFF &&
      mem_data_bus_oe[7:0] == 8'h00;
  endproperty
  a_rom: assert property (p_rom) else $error("rom read drives wrong lanes");
  property p_aux;
    @(posedge ref_clk) disable iff (rst)
    !aux_device_select_n |-> mem_data_bus_oe[31:16] == 16'hFFFF &&
      mem_data_bus_oe[15:8] == 8'h00;
  endproperty
  a_aux: assert property (p_aux) else $error("auxiliary access lanes wrong");
endmodule : fsdl_port

// >>> tb/fsdl_partner.sv
// Far-side model: four DRAM banks, boot ROM, auxiliary device, palette-DAC.
// Assumes the bench resolves the shared data bus and feeds it back as bus.
`timescale 1ns/10ps
module fsdl_partner (
  // Clock and resolved data bus
  input wire logic ref_clk,
  input wire logic [31:0] bus,
  // DRAM pins
  input wire logic [8:0] addr_banks_even_pair,
  input wire logic [8:0] addr_banks_odd_pair,
  input wire logic row_strobe_n,
  input wire logic [3:0] col_strobe_pair_a_n,
  input wire logic [3:0] col_strobe_pair_b_n,
  input wire logic write_en_banks_zero_three_n,
  input wire logic write_en_banks_one_two_n,
  input wire logic [3:0] bank_out_en_n,
  // Local device pins
  input wire logic boot_rom_select_n,
  input wire logic aux_device_select_n,
  input wire logic palette_dac_select_n,
  input wire logic pixel_load_clock,
  input wire logic pixel_load_enable_n,
  // Model outputs
  output logic [31:0] drv,
  output logic [31:0] pix
);
  logic [31:0] mem [bit [19:0]];
  logic [7:0] aux [bit [14:0]];
  logic [31:0] last_q;
  logic [8:0] row_e, row_o, col;
  logic [7:0] dac_reg;
  logic [3:0] cas;
  logic [1:0] wb, rb;
  logic a_act;
  logic ras_q = 1'b1;
  // Decode bank and column from whichever strobe pair is active
  always_comb begin
    cas = col_strobe_pair_a_n & col_strobe_pair_b_n;
    a_act = col_strobe_pair_a_n != 4'hF;
    col = a_act ? addr_banks_even_pair : addr_banks_odd_pair;
    wb = a_act ? (write_en_banks_zero_three_n ? 2'd2 : 2'd0)
               : (write_en_banks_one_two_n ? 2'd3 : 2'd1);
    rb = !bank_out_en_n[3] ? 2'd3 : !bank_out_en_n[2] ? 2'd2 :
         !bank_out_en_n[1] ? 2'd1 : 2'd0;
    // Undriven bus flips every cycle so stale data never passes for a read
    drv = ~last_q;
    if (bank_out_en_n != 4'hF) drv = mem[{rb, rb[0] ? row_o : row_e, col}];
    else if (!boot_rom_select_n && bus[31]) drv[7:0] = bus[23:16] ^ {1'b0, bus[30:24]};
    else if (!aux_device_select_n && bus[31]) drv[7:0] = aux[bus[30:16]];
    else if (!palette_dac_select_n && bus[31]) drv[15:8] = dac_reg;
  end
  // Storage updates on the memory clock
  always @(posedge ref_clk) begin
    last_q <= drv;
    // A DRAM takes its row only where the row strobe falls
    if (!row_strobe_n && ras_q && &cas) begin
      row_e = addr_banks_even_pair;
      row_o = addr_banks_odd_pair;
    end
    ras_q = row_strobe_n;
    if (cas != 4'hF && !(write_en_banks_zero_three_n && write_en_banks_one_two_n))
      for (int i = 0; i < 4; i++)
        if (!cas[i]) mem[{wb, wb[0] ? row_o : row_e, col}][i*8 +: 8] = bus[i*8 +: 8];
    if (!aux_device_select_n && !bus[31]) aux[bus[30:16]] = bus[7:0];
    if (!palette_dac_select_n && pixel_load_enable_n && !bus[31]) dac_reg = bus[15:8];
  end
  // Pixels are taken only at the rising load clock edge
  always @(posedge pixel_load_clock) if (!pixel_load_enable_n) pix = bus;
endmodule : fsdl_partner

// >>> tb/tb_framestore_dram_and_local_bus_port.sv
// Self-checking bench for the framestore DRAM and local bus port.
// Assumes fsdl_port and the far-side model fsdl_partner are compiled first.
`timescale 1ns/10ps
module tb_framestore_dram_and_local_bus_port;
  logic ref_clk = 0, rst = 1, req_valid = 0, req_write = 0, isolate_req = 1;
  fsdl_pkg::fsdl_target_t req_target = fsdl_pkg::TGT_DRAM;
  logic [1:0] req_bank = 0;
  logic [8:0] req_row = 0, req_col = 0, addr_banks_even_pair, addr_banks_odd_pair, ae, ao;
  logic [3:0] req_byte_en = 0, col_strobe_pair_a_n, col_strobe_pair_b_n, bank_out_en_n;
  logic [3:0] sa, sb, so;
  logic [14:0] req_loc_addr = 0;
  logic [31:0] req_wdata = 0, resp_rdata, mem_data_bus_in, mem_data_bus_out;
  logic [31:0] mem_data_bus_oe, drv, pix, rd;
  logic req_ready, resp_valid, transceiver_isolate, mem_clock_half, row_strobe_n;
  logic write_en_banks_zero_three_n, write_en_banks_one_two_n, boot_rom_select_n;
  logic aux_device_select_n, palette_dac_select_n, pixel_load_clock, pixel_load_enable_n;
  logic [1:0] sw;
  logic [2:0] ss;
  int err_total = 0, checks = 0, cyc = 0, n;
  always #10 ref_clk = ~ref_clk;
  // Each bit of the shared bus goes to whichever side enables it
  assign mem_data_bus_in = (mem_data_bus_oe & mem_data_bus_out) | (~mem_data_bus_oe & drv);
  fsdl_port i_dut (.ref_clk, .rst, .req_valid, .req_ready, .req_target, .req_write,
    .req_bank, .req_row, .req_col, .req_byte_en, .req_loc_addr, .req_wdata, .resp_valid,
    .resp_rdata, .isolate_req, .transceiver_isolate, .mem_clock_half, .mem_data_bus_in,
    .mem_data_bus_out, .mem_data_bus_oe, .addr_banks_even_pair, .addr_banks_odd_pair,
    .row_strobe_n, .col_strobe_pair_a_n, .col_strobe_pair_b_n, .write_en_banks_zero_three_n,
    .write_en_banks_one_two_n, .bank_out_en_n, .boot_rom_select_n, .aux_device_select_n,
    .palette_dac_select_n, .pixel_load_clock, .pixel_load_enable_n);
  fsdl_partner i_far (.ref_clk, .bus(mem_data_bus_in), .addr_banks_even_pair,
    .addr_banks_odd_pair, .row_strobe_n, .col_strobe_pair_a_n, .col_strobe_pair_b_n,
    .write_en_banks_zero_three_n, .write_en_banks_one_two_n, .bank_out_en_n,
    .boot_rom_select_n, .aux_device_select_n, .palette_dac_select_n, .pixel_load_clock,
    .pixel_load_enable_n, .drv, .pix);
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  // One request; records which pins moved while it ran, waits are bounded
  task automatic req(input fsdl_pkg::fsdl_target_t t, input logic w, input logic [1:0] b,
                     input logic [14:0] la, input logic [3:0] be, input logic [31:0] wd);
    {sa, sb, so, sw, ss, ae, ao} = '0;
    n = 0;
    @(posedge ref_clk);
    req_target <= t;
    req_write <= w;
    req_bank <= b;
    req_row <= {1'b1, b, la[5:0]};
    req_col <= la[8:0];
    req_byte_en <= be;
    req_loc_addr <= la;
    req_wdata <= wd;
    req_valid <= 1'b1;
    do @(negedge ref_clk); while (!req_ready && ++n < 20);
    @(posedge ref_clk);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
      sa |= ~col_strobe_pair_a_n;
      sb |= ~col_strobe_pair_b_n;
      so |= ~bank_out_en_n;
      sw |= ~{write_en_banks_one_two_n, write_en_banks_zero_three_n};
      ss |= ~{palette_dac_select_n, aux_device_select_n, boot_rom_select_n};
      ae |= addr_banks_even_pair;
      ao |= addr_banks_odd_pair;
      chk(32'((&bank_out_en_n) | (&{palette_dac_select_n, aux_device_select_n,
          boot_rom_select_n})), 32'h1);
    end while (!resp_valid && n < 20);
    chk(32'(n), 32'h5);
    rd = resp_rdata;
  endtask : req
  // ****************************************
  // Scenarios
  // ****************************************
  // Idle pin levels straight after reset
  task automatic t_reset();
    @(negedge ref_clk);
    chk({row_strobe_n, col_strobe_pair_a_n, col_strobe_pair_b_n,
         bank_out_en_n}, 32'h1FFF);
    chk({write_en_banks_zero_three_n, write_en_banks_one_two_n, transceiver_isolate,
         pixel_load_clock, pixel_load_enable_n}, 32'h1D);
    chk(mem_data_bus_oe, 32'h0);
  endtask : t_reset
  // Internal memory clock runs at half the input rate
  task automatic t_clock();
    logic h;
    @(negedge ref_clk);
    h = mem_clock_half;
    @(negedge ref_clk);
    chk(32'(h ^ mem_clock_half), 32'h1);
  endtask : t_clock
  // Isolation output follows its request both ways
  task automatic t_isolate();
    @(posedge ref_clk);
    isolate_req <= 0;
    repeat (2) @(negedge ref_clk);
    chk(32'(transceiver_isolate), 32'h0);
    @(posedge ref_clk);
    isolate_req <= 1;
    repeat (2) @(negedge ref_clk);
    chk(32'(transceiver_isolate), 32'h1);
  endtask : t_isolate
  // Full write, partial byte-lane write and read-back on every bank
  task automatic t_dram();
    logic [3:0] pa;
    logic [1:0] we;
    for (int b = 0; b < 4; b++) begin
      pa = b[0] ? 4'h0 : 4'hF;
      we = (b == 0 || b == 3) ? 2'h1 : 2'h2;
      req(fsdl_pkg::TGT_DRAM, 1'b1, 2'(b), 15'h0155 + 15'(b), 4'hF, 32'hA5A5_0000 | b);
      chk({18'h0, sw, sa, sb, so}, {18'h0, we, pa, ~pa, 4'h0});
      chk({30'h0, ae != 9'h0, ao != 9'h0}, b[0] ? 32'h1 : 32'h2);
      req(fsdl_pkg::TGT_DRAM, 1'b1, 2'(b), 15'h0155 + 15'(b), 4'h6, 32'h1234_5678);
      chk({24'h0, sa, sb}, b[0] ? 32'h06 : 32'h60);
      req(fsdl_pkg::TGT_DRAM, 1'b0, 2'(b), 15'h0155 + 15'(b), 4'hF, 32'h0);
      chk({26'h0, sw, so}, 32'(4'h1 << b));
      chk(rd, 32'hA534_5600 | b);
    end
  endtask : t_dram
  // ROM reads at 0x0123 and the top address, auxiliary and DAC register round trips, pixel load
  task automatic t_local();
    // The second ROM request asks for a write, which the port must still read
    for (int i = 0; i < 2; i++) begin
      req(fsdl_pkg::TGT_ROM, 1'(i), 2'h0, i ? 15'h7FFF : 15'h0123, 4'h0, 32'h0);
      chk(32'(ss), 32'h1);
      chk(rd, i ? 32'h0000_0080 : 32'h0000_0022);
    end
    req(fsdl_pkg::TGT_AUX, 1'b1, 2'h0, 15'h7ABC, 4'h0, 32'h0000_005A);
    chk(32'(ss), 32'h2);
    req(fsdl_pkg::TGT_AUX, 1'b0, 2'h0, 15'h7ABC, 4'h0, 32'h0);
    chk(rd, 32'h0000_005A);
    req(fsdl_pkg::TGT_DAC_REG, 1'b1, 2'h0, 15'h0002, 4'h0, 32'h0000_003C);
    chk(32'(ss), 32'h4);
    req(fsdl_pkg::TGT_DAC_REG, 1'b0, 2'h0, 15'h0002, 4'h0, 32'h0);
    chk(rd, 32'h0000_003C);
    // Pixel load asked as a read must still drive and load the word
    req(fsdl_pkg::TGT_DAC_PIX, 1'b0, 2'h0, 15'h0000, 4'h0, 32'hDEAD_BEEF);
    chk(32'(ss), 32'h4);
    chk(pix, 32'hDEAD_BEEF);
  endtask : t_local
  // Cycle ceiling cuts a hang short
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 0;
    t_reset();
    t_clock();
    t_isolate();
    t_dram();
    t_local();
    print_verdict();
  end
endmodule : tb_framestore_dram_and_local_bus_port
